/* dv/button_panel.sv */
// push buttons and switches wired to the multi-function terminals
// assumes the bench sets wanted contact levels with non-blocking writes
`default_nettype none
module button_panel #(
    parameter int HOLD = 6
) (
    input  wire logic       clock,
    input  wire logic [6:0] want,
    input  wire logic       glitch_ok,
    output var  logic [6:0] terminal_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int held [7] = '{default: HOLD};
    initial terminal_in = 7'h00;
    // a contact only changes once its level has stood; glitch_ok lets a bounce through
    always @(negedge clock) begin
        for (int i = 0; i < 7; i++) begin
            if (want[i] != terminal_in[i] && (glitch_ok || held[i] >= HOLD)) begin
                terminal_in[i] <= want[i];
                held[i]        <= 0;
            end else if (held[i] < HOLD) begin
                held[i] <= held[i] + 1;
            end
        end
    end
endmodule // button_panel
`default_nettype wire

/* dv/tb.sv */
// self-checking bench for the run command gating block
// assumes short qualifier and tick counts; terminals 0 fwd, 1 rev, 2 enable, 4 three-wire
`default_nettype none
module tb
    import run_gate_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    localparam int FWD = 0, REV = 1, EN = 2, STP = 4;
    logic                   clock = 1'b0;
    logic                   rst_b;
    logic [6:0]             want;
    logic                   glitch_ok;
    logic [6:0]             terminal_in;
    logic [5:0]             terminal_function_select [NUM_TERMINALS];
    logic                   cmd_source_sel, terminal_gated;
    logic [1:0]             stop_method;
    logic [QSTOP_WIDTH-1:0] qstop_time;
    logic                   forward_run_cmd, reverse_run_cmd, output_block, quick_ramp, drive_running;
    int                     error_cnt = 0, total_checks = 0, cycles = 0;
    always #4 clock = ~clock;
    button_panel #(.HOLD(6)) button_panel_inst (.clock(clock), .want(want), .glitch_ok(glitch_ok),
        .terminal_in(terminal_in));
    run_command_gating #(.STABLE_CYCLES(4), .TICK_CYCLES(3)) run_command_gating_inst (
        .clock(clock), .rst_b(rst_b), .terminal_in(terminal_in),
        .terminal_function_select(terminal_function_select), .cmd_source_sel(cmd_source_sel),
        .terminal_gated(terminal_gated), .stop_method(stop_method), .qstop_time(qstop_time),
        .forward_run_cmd(forward_run_cmd), .reverse_run_cmd(reverse_run_cmd),
        .output_block(output_block), .quick_ramp(quick_ramp), .drive_running(drive_running));
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge clock);
    endtask
    // reset clears contacts first so qualifiers restart from open terminals
    // contacts open within seven cycles of the panel's hold, so eight reset cycles cover them
    task automatic setup(input logic three, input logic src, input logic gated, input logic [1:0] m);
        want           <= 7'h00;
        rst_b          <= 1'b0;
        terminal_function_select[STP] <= three ? FUNC_3WIRE : 6'h00;
        cmd_source_sel <= src;
        terminal_gated <= gated;
        stop_method    <= m;
        qstop_time     <= 13'h0004;
        wt(8);
        rst_b <= 1'b1;
        wt(1);
    endtask
    task automatic pulse(input int b, input int n);
        want[b] <= 1'b1;
        wt(n);
        want[b] <= 1'b0;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_three();
        setup(1'b1, SRC_TERMINAL, EN_ALWAYS, STOP_COAST);
        check_bit(output_block, 1'b1);
        check_bit(drive_running, 1'b0);
        want[STP] <= 1'b1;
        wt(10);
        pulse(FWD, 8);
        wt(6);
        check_bit(forward_run_cmd, 1'b1);
        check_bit(output_block, 1'b0);
        pulse(REV, 8);
        wt(6);
        check_bit(reverse_run_cmd, 1'b0);
        want[STP] <= 1'b0;
        wt(12);
        check_bit(forward_run_cmd, 1'b0);
        check_bit(output_block, 1'b1);
        want[STP] <= 1'b1;
        glitch_ok <= 1'b1;
        wt(10);
        pulse(FWD, 2);
        wt(12);
        glitch_ok <= 1'b0;
        check_bit(forward_run_cmd, 1'b0);
        want[FWD] <= 1'b1;
        want[REV] <= 1'b1;
        wt(20);
        check_bit(drive_running, 1'b0);
        check_bit(output_block, 1'b1);
        // reverse alone latches once forward lets go
        want[FWD] <= 1'b0;
        wt(12);
        check_bit(reverse_run_cmd, 1'b1);
        check_bit(forward_run_cmd, 1'b0);
        // forward joining a running reverse stops the drive
        want[FWD] <= 1'b1;
        wt(12);
        check_bit(drive_running, 1'b0);
        check_bit(reverse_run_cmd, 1'b0);
        $display("test three_wire done");
    endtask
    task automatic t_source();
        setup(1'b1, 1'b0, EN_ALWAYS, STOP_COAST);
        want[STP] <= 1'b1;
        wt(10);
        pulse(FWD, 8);
        wt(6);
        check_bit(drive_running, 1'b0);
        $display("test source done");
    endtask
    task automatic t_gate(input logic [1:0] m);
        setup(1'b0, SRC_TERMINAL, EN_GATED, m);
        want[FWD] <= 1'b1;
        wt(12);
        check_bit(drive_running, 1'b0);
        want[EN] <= 1'b1;
        wt(12);
        check_bit(forward_run_cmd, 1'b1);
        want[EN] <= 1'b0;
        wt(12);
        check_bit(output_block, 1'b1);
        check_bit(drive_running, 1'b0);
        terminal_gated <= EN_ALWAYS;
        wt(12);
        check_bit(drive_running, 1'b1);
        $display("test gate %0d done", m);
    endtask
    task automatic t_quick(input logic [1:0] m);
        setup(1'b0, SRC_TERMINAL, EN_GATED, m);
        want[FWD] <= 1'b1;
        want[EN]  <= 1'b1;
        wt(12);
        check_bit(drive_running, 1'b1);
        want[EN] <= 1'b0;
        wt(10);
        check_bit(quick_ramp, 1'b1);
        check_bit(output_block, 1'b0);
        check_bit(forward_run_cmd, 1'b0);
        wt(15);
        check_bit(output_block, 1'b1);
        check_bit(quick_ramp, 1'b0);
        want[EN] <= 1'b1;
        wt(12);
        check_bit(drive_running, m == STOP_QUICK_RES);
        if (m == STOP_QUICK) begin
            want[FWD] <= 1'b0;
            wt(10);
            want[FWD] <= 1'b1;
            wt(12);
            check_bit(drive_running, 1'b1);
        end
        $display("test quick_stop %0d done", m);
    endtask
    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    // a hang is cut short well beyond the few hundred cycles the scenarios need
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            finish_test();
        end
    end
    initial begin
        rst_b = 1'b0;
        want = 7'h00;
        glitch_ok = 1'b0;
        terminal_function_select = '{default: 6'h00};
        terminal_function_select[FWD] = FUNC_FWD;
        terminal_function_select[REV] = FUNC_REV;
        terminal_function_select[EN]  = FUNC_RUN_EN;
        cmd_source_sel = SRC_TERMINAL;
        terminal_gated = EN_ALWAYS;
        stop_method = STOP_COAST;
        qstop_time = QSTOP_DEFAULT;
        t_three();
        t_source();
        t_gate(STOP_COAST);
        t_gate(2'h3);
        t_quick(STOP_QUICK);
        t_quick(STOP_QUICK_RES);
        finish_test();
    end
endmodule // tb
`default_nettype wire

/* hw/input_qualifier.sv */
// stability filter for one terminal input
// assumes the input is already synchronous to clock
`default_nettype none
module input_qualifier #(
    parameter int STABLE_CYCLES = 125000
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic raw,
    output var  logic qualified
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);
    logic [CW-1:0] cnt_q;
    logic          qual_q;
    wire           differs = (raw != qual_q);
    wire           done    = (cnt_q == CW'(STABLE_CYCLES - 1));
    // --------------------------------------------------------------
    // accept a new level only after it stayed put long enough
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_q  <= '0;
            qual_q <= 1'b0;
        end else if (!differs) begin
            cnt_q  <= '0;                       // glitch restarts the wait
        end else if (done) begin
            cnt_q  <= '0;
            qual_q <= raw;
        end else begin
            cnt_q  <= cnt_q + 1'b1;
        end
    end
    assign qualified = qual_q;
endmodule // input_qualifier
`default_nettype wire

/* hw/run_command_gating.sv */
// run and stop command interpreter for multi-function terminals
// assumes terminal levels synchronous to clock, active high when on
// Operation
// [R01] in three-wire mode with terminal command source a short forward or reverse press stays latched.
// [R02] a terminal pulse of at least one millisecond is taken as a valid command.
// [R03] in three-wire mode forward and reverse together stop the drive.
// [R04] a terminal set to run enable gates run commands under safe operation mode.
// [R05] with gated selection run is only seen while enable is on, always-enabled never gates.
// [R06] stop method takes 0 to 2, and coast blocks the output at once when enable drops.
// [R07] quick stop ramps over the quick stop time, halts, and needs a fresh run command to restart.
// [R08] quick stop resume ramps and halts, then restarts once run is asserted while enable is on.
// [R09] quick stop time is 0.0 to 600.0 s, default 5.0 s, used by both quick stop methods.
// [R10] releasing the three-wire terminal clears the latched run command, a closed stop button.
// [R11] every terminal must stay stable for the least input time before it is acted on.
`default_nettype none
module run_command_gating
    import run_gate_pkg::*;
#(
    parameter int STABLE_CYCLES = run_gate_pkg::MIN_INPUT_CYCLES,
    parameter int TICK_CYCLES   = run_gate_pkg::QSTOP_TICK_CYCLES
) (
    input  wire logic                                  clock,
    input  wire logic                                  rst_b,
    input  wire logic [run_gate_pkg::NUM_TERMINALS-1:0] terminal_in,
    input  wire logic [5:0]                            terminal_function_select [run_gate_pkg::NUM_TERMINALS],
    input  wire logic                                  cmd_source_sel,
    input  wire logic                                  terminal_gated,
    input  wire logic [1:0]                            stop_method,
    input  wire logic [run_gate_pkg::QSTOP_WIDTH-1:0]  qstop_time,
    output var  logic                                  forward_run_cmd,
    output var  logic                                  reverse_run_cmd,
    output var  logic                                  output_block,
    output var  logic                                  quick_ramp,
    output var  logic                                  drive_running
);
    import run_gate_pkg::*;

    // --------------------------------------------------------------
    // terminal qualification
    // --------------------------------------------------------------
    logic [NUM_TERMINALS-1:0] term_q;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERMINALS; gi++) begin : g_qual
            input_qualifier #(.STABLE_CYCLES(STABLE_CYCLES)) u_qual ( // R11 R02
                .clock     (clock),
                .rst_b     (rst_b),
                .raw       (terminal_in[gi]),
                .qualified (term_q[gi])
            );
        end
    endgenerate

    // --------------------------------------------------------------
    // function decode: which terminals carry each function
    // --------------------------------------------------------------
    logic fwd_in, rev_in, en_in, wire3_in, en_assigned, wire3_assigned;
    always_comb begin
        fwd_in         = 1'b0;
        rev_in         = 1'b0;
        en_in          = 1'b0;
        wire3_in       = 1'b0;
        en_assigned    = 1'b0;
        wire3_assigned = 1'b0;
        for (int i = 0; i < NUM_TERMINALS; i++) begin
            if (terminal_function_select[i] == FUNC_FWD) fwd_in = fwd_in | term_q[i];
            if (terminal_function_select[i] == FUNC_REV) rev_in = rev_in | term_q[i];
            if (terminal_function_select[i] == FUNC_RUN_EN) begin
                en_assigned = 1'b1;
                en_in       = en_in | term_q[i];
            end
            if (terminal_function_select[i] == FUNC_3WIRE) begin
                wire3_assigned = 1'b1;
                wire3_in       = wire3_in | term_q[i];
            end
        end
    end

    // --------------------------------------------------------------
    // three-wire latch and run request
    // --------------------------------------------------------------
    logic fwd_latch_q, rev_latch_q;
    wire three_wire = wire3_assigned & (cmd_source_sel == SRC_TERMINAL);        // R01
    wire both_cmd   = fwd_in & rev_in;                                         // R03
    wire fwd_req    = three_wire ? fwd_latch_q : (fwd_in & ~rev_in);
    wire rev_req    = three_wire ? rev_latch_q : (rev_in & ~fwd_in);
    wire run_req    = (fwd_req | rev_req) & (cmd_source_sel == SRC_TERMINAL);

    // a press latches; stop button release or both pressed clears
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            fwd_latch_q <= 1'b0;
            rev_latch_q <= 1'b0;
        end else if (!three_wire || !wire3_in || both_cmd) begin
            fwd_latch_q <= 1'b0;                                               // R10 R03
            rev_latch_q <= 1'b0;
        end else begin
            fwd_latch_q <= fwd_latch_q | (fwd_in & ~rev_latch_q);              // R01
            rev_latch_q <= rev_latch_q | (rev_in & ~fwd_latch_q);
        end
    end

    // --------------------------------------------------------------
    // run enable gate
    // --------------------------------------------------------------
    // without an enable terminal there is nothing to gate on
    wire gating   = en_assigned & (terminal_gated == EN_GATED);                 // R04 R05
    wire enable_ok = ~gating | en_in;                                          // R05
    wire method_ok = (stop_method <= STOP_QUICK_RES);                          // R06
    wire [1:0] method = method_ok ? stop_method : STOP_COAST;

    // --------------------------------------------------------------
    // quick stop timer in 0.1 s units
    // --------------------------------------------------------------
    localparam int TW = $clog2(TICK_CYCLES + 1);
    logic [TW-1:0]          tick_q;
    logic [QSTOP_WIDTH-1:0] ramp_q;
    wire [QSTOP_WIDTH-1:0]  qtime = (qstop_time > QSTOP_MAX) ? QSTOP_MAX : qstop_time; // R09
    wire tick = (tick_q == TW'(TICK_CYCLES - 1));

    // --------------------------------------------------------------
    // stop state machine
    // --------------------------------------------------------------
    run_state_t state_q, state_d;
    logic       run_seen_q;    // rearm seen since halt (run dropped, or enable on in resume mode), needed for re-entry
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (run_req && enable_ok) state_d = ST_RUN;
            ST_RUN: begin
                if (!run_req) state_d = ST_IDLE;
                else if (!enable_ok) begin
                    if (method == STOP_COAST) state_d = ST_IDLE;                // R06
                    else state_d = ST_RAMP;                                    // R07 R08
                end
            end
            ST_RAMP: if (ramp_q == '0) state_d = ST_HALT;                       // R09
            ST_HALT: begin
                // plain quick stop needs a fresh edge of run; resume restarts once enable returns with run held
                if (run_req && enable_ok && run_seen_q) state_d = ST_RUN;        // R07 R08
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // quick stop counts down the set time, whole 0.1 s steps
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            tick_q <= '0;
            ramp_q <= QSTOP_DEFAULT;
        end else if (state_q != ST_RAMP) begin
            tick_q <= '0;
            ramp_q <= qtime;
        end else if (tick) begin
            tick_q <= '0;
            ramp_q <= ramp_q - 1'b1;
        end else begin
            tick_q <= tick_q + 1'b1;
        end
    end

    // resume mode only needs run with enable on; plain quick stop needs run re-entered
    wire rearm = (method == STOP_QUICK_RES) ? enable_ok : ~run_req;
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            run_seen_q <= 1'b0;
        end else if (state_q != ST_HALT) begin
            run_seen_q <= 1'b0;
        end else if (rearm) begin
            run_seen_q <= 1'b1;                                                // R07 R08
        end
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            forward_run_cmd <= 1'b0;
            reverse_run_cmd <= 1'b0;
            output_block    <= 1'b1;
            quick_ramp      <= 1'b0;
            drive_running   <= 1'b0;
        end else begin
            forward_run_cmd <= (state_d == ST_RUN) & fwd_req;
            reverse_run_cmd <= (state_d == ST_RUN) & rev_req;
            output_block    <= (state_d == ST_IDLE) | (state_d == ST_HALT);
            quick_ramp      <= (state_d == ST_RAMP);
            drive_running   <= (state_d == ST_RUN) | (state_d == ST_RAMP);
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    a_both_stop: assert property (@(posedge clock) disable iff (!rst_b) // R03
        (three_wire && both_cmd) |=> !fwd_latch_q && !rev_latch_q)
        else $error("both commands did not clear latch");
    a_coast_block: assert property (@(posedge clock) disable iff (!rst_b) // R06
        (state_q == ST_RUN && run_req && !enable_ok && method == STOP_COAST) |=> output_block)
        else $error("coast did not block output");
    a_gate_run: assert property (@(posedge clock) disable iff (!rst_b) // R05
        (state_q == ST_IDLE && !enable_ok) |=> !drive_running)
        else $error("run started without enable");
    a_ramp_enter: assert property (@(posedge clock) disable iff (!rst_b) // R07
        (state_q == ST_RUN && run_req && !enable_ok && method != STOP_COAST) |=> quick_ramp)
        else $error("quick stop ramp not entered");
    a_halt_hold: assert property (@(posedge clock) disable iff (!rst_b) // R07
        (state_q == ST_HALT && !run_seen_q) |=> state_q != ST_RUN)
        else $error("restart without rearm");
    a_latch_hold: assert property (@(posedge clock) disable iff (!rst_b) // R01
        (three_wire && wire3_in && !both_cmd && fwd_latch_q) |=> fwd_latch_q)
        else $error("latched forward lost");
    a_stop_release: assert property (@(posedge clock) disable iff (!rst_b) // R10
        (three_wire && !wire3_in) |=> !fwd_latch_q && !rev_latch_q)
        else $error("stop button did not clear latch");
    a_ramp_time: assert property (@(posedge clock) disable iff (!rst_b) // R09
        (state_q == ST_RAMP && ramp_q != '0) |=> state_q == ST_RAMP)
        else $error("ramp ended early");
    a_qual_stable: assert property (@(posedge clock) disable iff (!rst_b) // R11
        $rose(term_q[0]) |-> $past(terminal_in[0]))
        else $error("qualified without raw level");
endmodule // run_command_gating
`default_nettype wire

/* hw/run_gate_pkg.sv */
// constants shared by the run command gating block
// assumes a 125 MHz clock and synchronous terminal inputs
`default_nettype none
package run_gate_pkg;
    // --------------------------------------------------------------
    // clock and timing
    // --------------------------------------------------------------
    localparam int CLOCK_HZ          = 125_000_000;
    localparam int MIN_INPUT_TIME_US = 1000;                 // 1 ms least pulse
    localparam int MIN_INPUT_CYCLES  = (CLOCK_HZ / 1_000_000) * MIN_INPUT_TIME_US;
    localparam int QSTOP_TICK_CYCLES = CLOCK_HZ / 10;        // one 0.1 s unit
    localparam int QSTOP_WIDTH       = 13;                   // 0.0 .. 600.0 s in 0.1 s
    localparam logic [QSTOP_WIDTH-1:0] QSTOP_MAX     = 13'h1770; // 600.0 s
    localparam logic [QSTOP_WIDTH-1:0] QSTOP_DEFAULT = 13'h0032; // 5.0 s
    // --------------------------------------------------------------
    // terminal function codes
    // --------------------------------------------------------------
    localparam int          NUM_TERMINALS = 7;
    localparam logic [5:0]  FUNC_FWD      = 6'h01;
    localparam logic [5:0]  FUNC_REV      = 6'h02;
    localparam logic [5:0]  FUNC_RUN_EN   = 6'h0D;           // 13
    localparam logic [5:0]  FUNC_3WIRE    = 6'h0E;           // 14
    // --------------------------------------------------------------
    // modes
    // --------------------------------------------------------------
    localparam logic        SRC_TERMINAL   = 1'b1;
    localparam logic        EN_ALWAYS      = 1'b0;
    localparam logic        EN_GATED       = 1'b1;
    localparam logic [1:0]  STOP_COAST     = 2'h0;
    localparam logic [1:0]  STOP_QUICK     = 2'h1;
    localparam logic [1:0]  STOP_QUICK_RES = 2'h2;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_RUN  = 4'h2,
        ST_RAMP = 4'h4,
        ST_HALT = 4'h8
    } run_state_t;
endpackage : run_gate_pkg
`default_nettype wire
